// ### hdl/mcet_pkg.sv
// package: register map, fields and reset values of the master card logic
package mcet_pkg;
    // register byte offsets
    localparam logic [7:0] mcet_off_ipi       = 8'h00;
    localparam logic [7:0] mcet_off_chan_en   = 8'h04;
    localparam logic [7:0] mcet_off_adc_ctl   = 8'h08;
    localparam logic [7:0] mcet_off_adc_data  = 8'h0c;
    localparam logic [7:0] mcet_off_analog    = 8'h10;
    localparam logic [7:0] mcet_off_tmr_ctl   = 8'h14;
    localparam logic [7:0] mcet_off_tmr_load  = 8'h18;
    localparam logic [7:0] mcet_off_tmr_count = 8'h1c;
    localparam logic [7:0] mcet_off_sync_div  = 8'h20;
    localparam logic [7:0] mcet_off_video     = 8'h24;
    localparam logic [7:0] mcet_off_irq_stat  = 8'h28;
    localparam logic [7:0] mcet_off_irq_mask  = 8'h2c;
    // irq status bit positions
    localparam int mcet_irq_ipi1  = 0;
    localparam int mcet_irq_ipi2  = 1;
    localparam int mcet_irq_timer = 2;
    localparam int mcet_irq_adc   = 3;
    localparam int mcet_irq_bits  = 4;
    // control field positions
    localparam int mcet_tmr_run  = 0;
    localparam int mcet_tmr_ext  = 1;
    localparam int mcet_tmr_rec  = 2;
    localparam int mcet_adc_go   = 0;
    localparam int mcet_ipi_to1  = 0;
    localparam int mcet_ipi_to2  = 1;
    // sizes
    localparam int mcet_chan_n   = 8;
    localparam int mcet_tmr_w    = 16;
    localparam int mcet_div_w    = 16;
    localparam int mcet_adc_w    = 8;
    localparam int mcet_ana_w    = 24;
    // reset values
    localparam logic [31:0] mcet_rst_word = 32'h0000_0000;
    // ahb transfer type
    localparam logic [1:0] mcet_htrans_nonseq = 2'h2;
    localparam logic [1:0] mcet_htrans_seq    = 2'h3;
    // conversion states
    typedef enum logic [1:0] {
        mcet_adc_idle,
        mcet_adc_wait_pulse,
        mcet_adc_convert
    } mcet_adc_state_type;
endpackage : mcet_pkg

// ### hdl/mcet_divider.sv
// programmable divider: one-cycle enable per div_ratio input ticks
`timescale 1ns/1ps
`default_nettype none
module mcet_divider #(
    parameter int width = 16
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             rst,
    // ticks in and divided ticks out
    input  wire logic             tick_in,
    input  wire logic [width-1:0] div_ratio,
    output var  logic             tick_out
);
    if (width < 2) begin : g_bad_width
        $error("mcet_divider width too small");
    end

    typedef struct packed {
        logic [width-1:0] cnt;
        logic             out;
    } mcet_div_state_type;

    mcet_div_state_type s_q;
    mcet_div_state_type s_d;

    // count input ticks, pulse on reaching ratio (ratio 0 acts as 1)
    always_comb begin
        s_d     = s_q;
        s_d.out = 1'b0;
        if (tick_in) begin
            if (s_q.cnt + 1'b1 >= div_ratio) begin
                s_d.cnt = '0;
                s_d.out = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick_out = s_q.out;
endmodule : mcet_divider
`default_nettype wire

// ### hdl/mcet_top.sv
// master card logic: ipi, channel enables, sampler handshake, event timer
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module mcet_top
    import mcet_pkg::*;
#(
    parameter int chan_n = mcet_pkg::mcet_chan_n
) (
    // clock and reset
    input  wire logic                           mclk,
    input  wire logic                           rst,
    // ahb-lite slave
    input  wire logic                           hsel,
    input  wire logic [7:0]                     haddr,
    input  wire logic [1:0]                     htrans,
    input  wire logic                           hwrite,
    input  wire logic [2:0]                     hsize,
    input  wire logic [31:0]                    hwdata,
    input  wire logic                           hready,
    output var  logic [31:0]                    hrdata,
    output var  logic                           hreadyout,
    output var  logic                           hresp,
    // channel cards and converter
    input  wire logic                           chan1_pulse,
    input  wire logic                           adc_done,
    input  wire logic [mcet_pkg::mcet_adc_w-1:0] adc_result,
    output var  logic                           adc_start,
    output var  logic [chan_n-1:0]              chan_wr_en,
    output var  logic [mcet_pkg::mcet_ana_w-1:0] analog_ctl,
    // processor control
    output var  logic                           cpu1_halt,
    output var  logic                           cpu1_ipi,
    output var  logic                           cpu2_ipi,
    output var  logic                           irq,
    // sequencer events, sync input, video map
    input  wire logic                           perf_event,
    input  wire logic                           sync_tick,
    output var  logic                           video_map
);
    import mcet_pkg::*;

    if (chan_n < 1 || chan_n > 32) begin : g_bad_chan_n
        $error("chan_n out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic                    ph_act;
        logic                    ph_wr;
        logic [7:0]              ph_addr;
        logic [31:0]             rdata;
        logic [chan_n-1:0]       chan_en;
        logic [mcet_ana_w-1:0]   ana;
        logic [mcet_adc_w-1:0]   adc_val;
        mcet_adc_state_type      adc_st;
        logic                    halt;
        logic                    start;
        logic [2:0]              tctl;
        logic [mcet_tmr_w-1:0]   tload;
        logic [mcet_tmr_w-1:0]   tcnt;
        logic [mcet_tmr_w-1:0]   tcap;
        logic [mcet_div_w-1:0]   div;
        logic                    video;
        logic [mcet_irq_bits-1:0] stat;
        logic [mcet_irq_bits-1:0] mask;
        logic                    irq;
    } mcet_state_type;

    mcet_state_type s_q;
    mcet_state_type s_d;
    logic           ext_tick;

    // divider on the external sync ticks
    mcet_divider #(.width(mcet_div_w)) u_div (
        .mclk      (mclk),
        .rst       (rst),
        .tick_in   (sync_tick),
        .div_ratio (s_q.div),
        .tick_out  (ext_tick)
    );

    // register word index helper
    function automatic logic is_reg(input logic [7:0] a,
                                    input logic [7:0] off);
        return a[7:2] == off[7:2];
    endfunction : is_reg

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        logic                     wr;
        logic                     tick;
        logic [mcet_irq_bits-1:0] set;
        logic [mcet_irq_bits-1:0] clr;
        wr   = 1'b0;
        tick = 1'b0;
        set  = '0;
        clr  = '0;
        s_d  = s_q;
        s_d.start = 1'b0;
        // address phase capture
        if (hready) begin
            s_d.ph_act  = hsel && (htrans == mcet_htrans_nonseq ||
                                   htrans == mcet_htrans_seq);
            s_d.ph_wr   = hwrite;
            s_d.ph_addr = haddr;
        end
        // read data for the next data phase
        s_d.rdata = mcet_rst_word;
        if (hready && hsel && !hwrite) begin
            if (is_reg(haddr, mcet_off_ipi))
                s_d.rdata = 32'(s_q.stat[mcet_irq_ipi2:mcet_irq_ipi1]);
            else if (is_reg(haddr, mcet_off_chan_en))
                s_d.rdata = 32'(s_q.chan_en);
            else if (is_reg(haddr, mcet_off_adc_ctl))
                s_d.rdata = 32'(s_q.halt);
            else if (is_reg(haddr, mcet_off_adc_data))
                s_d.rdata = 32'(s_q.adc_val);
            else if (is_reg(haddr, mcet_off_analog))
                s_d.rdata = 32'(s_q.ana);
            else if (is_reg(haddr, mcet_off_tmr_ctl))
                s_d.rdata = 32'(s_q.tctl);
            else if (is_reg(haddr, mcet_off_tmr_load))
                s_d.rdata = 32'(s_q.tload);
            else if (is_reg(haddr, mcet_off_tmr_count))
                s_d.rdata = 32'(s_q.tctl[mcet_tmr_rec] ? s_q.tcap
                                                       : s_q.tcnt);
            else if (is_reg(haddr, mcet_off_sync_div))
                s_d.rdata = 32'(s_q.div);
            else if (is_reg(haddr, mcet_off_video))
                s_d.rdata = 32'(s_q.video);
            else if (is_reg(haddr, mcet_off_irq_stat))
                s_d.rdata = 32'(s_q.stat);
            else if (is_reg(haddr, mcet_off_irq_mask))
                s_d.rdata = 32'(s_q.mask);
        end
        // data phase writes
        wr = s_q.ph_act && s_q.ph_wr;
        if (wr) begin
            if (is_reg(s_q.ph_addr, mcet_off_ipi)) begin
                set[mcet_irq_ipi1] = hwdata[mcet_ipi_to1];
                set[mcet_irq_ipi2] = hwdata[mcet_ipi_to2];
            end
            if (is_reg(s_q.ph_addr, mcet_off_chan_en))
                s_d.chan_en = hwdata[chan_n-1:0];
            if (is_reg(s_q.ph_addr, mcet_off_adc_ctl) &&
                hwdata[mcet_adc_go] && s_q.adc_st == mcet_adc_idle) begin
                s_d.adc_st = mcet_adc_wait_pulse;
                s_d.halt   = 1'b1;
            end
            if (is_reg(s_q.ph_addr, mcet_off_analog))
                s_d.ana = hwdata[mcet_ana_w-1:0];
            if (is_reg(s_q.ph_addr, mcet_off_tmr_ctl))
                s_d.tctl = hwdata[2:0];
            if (is_reg(s_q.ph_addr, mcet_off_tmr_load)) begin
                s_d.tload = hwdata[mcet_tmr_w-1:0];
                s_d.tcnt  = hwdata[mcet_tmr_w-1:0];
                clr[mcet_irq_timer] = 1'b1;
            end
            if (is_reg(s_q.ph_addr, mcet_off_sync_div))
                s_d.div = hwdata[mcet_div_w-1:0];
            if (is_reg(s_q.ph_addr, mcet_off_video))
                s_d.video = hwdata[0];
            if (is_reg(s_q.ph_addr, mcet_off_irq_stat))
                clr = clr | hwdata[mcet_irq_bits-1:0];
            if (is_reg(s_q.ph_addr, mcet_off_irq_mask))
                s_d.mask = hwdata[mcet_irq_bits-1:0];
        end
        // conversion handshake paced by channel one
        case (s_q.adc_st)
            mcet_adc_idle: begin
                s_d.halt = s_d.halt;
            end
            mcet_adc_wait_pulse: begin
                if (chan1_pulse) begin
                    s_d.start  = 1'b1;
                    s_d.adc_st = mcet_adc_convert;
                end
            end
            mcet_adc_convert: begin
                if (adc_done) begin
                    s_d.adc_val = adc_result;
                    s_d.halt    = 1'b0;
                    s_d.adc_st  = mcet_adc_idle;
                    set[mcet_irq_adc] = 1'b1;
                end
            end
            default: begin
                s_d.adc_st = mcet_adc_idle;
                s_d.halt   = 1'b0;
            end
        endcase
        // event timer time base
        tick = s_q.tctl[mcet_tmr_ext] ? ext_tick : 1'b1;
        if (s_q.tctl[mcet_tmr_run] && tick) begin
            if (s_q.tctl[mcet_tmr_rec]) begin
                s_d.tcnt = s_q.tcnt + 1'b1;
            end else if (s_q.tcnt != '0) begin
                s_d.tcnt = s_q.tcnt - 1'b1;
                if (s_q.tcnt == mcet_tmr_w'(1))
                    set[mcet_irq_timer] = 1'b1;
            end
        end
        // record mode: latch interval (this tick included) and restart
        if (s_q.tctl[mcet_tmr_run] && s_q.tctl[mcet_tmr_rec] && perf_event)
        begin
            s_d.tcap = s_d.tcnt;
            s_d.tcnt = '0;
            set[mcet_irq_timer] = 1'b1;
        end
        // sticky status: set wins over clear
        s_d.stat = (s_q.stat & ~clr) | set;
        s_d.irq  = |(s_d.stat & s_d.mask);
    end

    // state register
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from flip-flops; hreadyout and hresp are tied to constants
    assign hrdata     = s_q.rdata;
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign adc_start  = s_q.start;
    assign chan_wr_en = s_q.chan_en;
    assign analog_ctl = s_q.ana;
    assign cpu1_halt  = s_q.halt;
    assign cpu1_ipi   = s_q.stat[mcet_irq_ipi1];
    assign cpu2_ipi   = s_q.stat[mcet_irq_ipi2];
    assign irq        = s_q.irq;
    assign video_map  = s_q.video;

    ////////////////////////////////////////////////////////////////////////
    // assertions
    logic wr_any;
    assign wr_any = s_q.ph_act && s_q.ph_wr; // write data phase
    sequence s_adc_go;
        s_q.adc_st == mcet_adc_wait_pulse && chan1_pulse;
    endsequence
    property p_halt_on_go;
        @(posedge mclk) disable iff (rst)
        s_adc_go |=> cpu1_halt && adc_start;
    endproperty
    a_halt_on_go: assert property (p_halt_on_go)
        else $error("halt or start missing after channel pulse");
    property p_halt_hold;
        @(posedge mclk) disable iff (rst)
        s_q.adc_st == mcet_adc_convert && !adc_done |=> cpu1_halt;
    endproperty
    a_halt_hold: assert property (p_halt_hold)
        else $error("halt dropped during conversion");
    property p_release;
        @(posedge mclk) disable iff (rst)
        s_q.adc_st == mcet_adc_convert && adc_done
            |=> !cpu1_halt && s_q.adc_val == $past(adc_result);
    endproperty
    a_release: assert property (p_release)
        else $error("halt not released with result");
    property p_tmr_fire;
        @(posedge mclk) disable iff (rst)
        s_q.tctl == 3'h1 && s_q.tcnt == mcet_tmr_w'(1)
            |=> s_q.stat[mcet_irq_timer];
    endproperty
    a_tmr_fire: assert property (p_tmr_fire)
        else $error("timer expiry missed");
    property p_int_count;
        @(posedge mclk) disable iff (rst)
        s_q.tctl == 3'h5 && !perf_event && !wr_any
            |=> s_q.tcnt == $past(s_q.tcnt) + 1'b1;
    endproperty
    a_int_count: assert property (p_int_count)
        else $error("internal sync not counting clock");
    property p_ext_hold;
        @(posedge mclk) disable iff (rst)
        s_q.tctl[mcet_tmr_ext] && !ext_tick && !perf_event && !wr_any
            |=> $stable(s_q.tcnt);
    endproperty
    a_ext_hold: assert property (p_ext_hold)
        else $error("external timer moved without tick");
    property p_sticky;
        @(posedge mclk) disable iff (rst)
        s_q.stat[mcet_irq_ipi2] && !wr_any |=> cpu2_ipi;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("ipi lost without clear");
    property p_tmr_sticky;
        @(posedge mclk) disable iff (rst)
        s_q.stat[mcet_irq_timer] && !wr_any |=> s_q.stat[mcet_irq_timer];
    endproperty
    a_tmr_sticky: assert property (p_tmr_sticky)
        else $error("timer interrupt lost without ack");
    property p_irq;
        @(posedge mclk) disable iff (rst)
        irq == |(s_q.stat & s_q.mask);
    endproperty
    a_irq: assert property (p_irq)
        else $error("irq output mismatch");
endmodule : mcet_top
`default_nettype wire

// ### sim/mcet_conv_model.sv
// converter and channel-one pace source seen from the master card
`timescale 1ns/1ps
`default_nettype none
module mcet_conv_model #(
    parameter int lat = 6,
    parameter int per = 5
) (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    // bench control and design request
    input  wire logic       pace_en,
    input  wire logic [7:0] res_val,
    input  wire logic       adc_start,
    // answers to the design
    output var  logic       chan1_pulse,
    output var  logic       adc_done,
    output var  logic [7:0] adc_result
);
    int pc;
    int cc;
    // one pace pulse every per cycles while the channel runs
    always @(posedge mclk) begin
        pc <= (rst || pc >= per - 1) ? 0 : pc + 1;
        chan1_pulse <= !rst && pace_en && pc == per - 1;
    end
    // conversion lasts lat cycles; result bus toggles outside done
    always @(posedge mclk) begin
        adc_done <= 1'b0;
        adc_result <= ~adc_result;
        if (rst) begin
            cc <= 0;
            adc_result <= 8'h00;
        end else if (adc_start) begin
            cc <= lat;
        end else if (cc > 0) begin
            cc <= cc - 1;
        end
        if (!rst && cc == 1) begin
            adc_done <= 1'b1;
            adc_result <= res_val;
        end
    end
endmodule : mcet_conv_model
`default_nettype wire

// ### sim/tb_master_card_event_timer_and_sampler.sv
// self-checking bench for the master card logic
`timescale 1ns/1ps
`default_nettype none
module tb_master_card_event_timer_and_sampler;
    import mcet_pkg::*;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        chan1_pulse;
    logic        adc_done;
    logic        adc_start;
    logic        pace_en = 1'b0;
    logic [7:0]  adc_result;
    logic [7:0]  chan_wr_en;
    logic [23:0] analog_ctl;
    logic        cpu1_halt, cpu1_ipi, cpu2_ipi, irq, video_map;
    logic        perf_event = 1'b0;
    logic        sync_tick = 1'b0;
    logic [31:0] rd;
    int          err_count = 0;
    int          total_checks = 0;
    int          starts = 0;
    int          n;
    always #10 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////
    // design and far-side model
    mcet_top uut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .chan1_pulse(chan1_pulse), .adc_done(adc_done),
        .adc_result(adc_result), .adc_start(adc_start),
        .chan_wr_en(chan_wr_en), .analog_ctl(analog_ctl),
        .cpu1_halt(cpu1_halt), .cpu1_ipi(cpu1_ipi), .cpu2_ipi(cpu2_ipi),
        .irq(irq), .perf_event(perf_event), .sync_tick(sync_tick),
        .video_map(video_map));
    mcet_conv_model conv (.mclk(mclk), .rst(rst), .pace_en(pace_en),
        .res_val(8'h5a), .adc_start(adc_start), .chan1_pulse(chan1_pulse),
        .adc_done(adc_done), .adc_result(adc_result));
    ////////////////////////////////////////////////////////////////////////
    // compare helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_in(input logic [31:0] got, input int lo, input int hi);
        total_checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            err_count++;
            $display("Error at %0t: got %h expected %h..%h", $time, got,
                     lo, hi);
        end
    endtask : chk_in
    task automatic cyc(input int c);
        repeat (c) @(posedge mclk);
    endtask : cyc
    // one bus transfer: address phase, then data phase
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] q);
        int k;
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= mcet_htrans_nonseq;
        k = 0;
        @(posedge mclk);
        while (hreadyout !== 1'b1 && k < 50) begin
            @(posedge mclk);
            k++;
        end
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge mclk);
        while (hreadyout !== 1'b1 && k < 100) begin
            @(posedge mclk);
            k++;
        end
        q = hrdata;
        if (k >= 50) err_count++;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask : rdc
    task automatic tick(input int c);
        repeat (c) begin
            sync_tick <= 1'b1;
            cyc(1);
            sync_tick <= 1'b0;
            cyc(5);
        end
    endtask : tick
    task automatic wait_irq;
        n = 0;
        while (irq !== 1'b1 && n < 100) begin
            cyc(1);
            n++;
        end
    endtask : wait_irq
    task automatic wrap_up;
        if (err_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////////////
    // every conversion start must find processor one halted
    always @(posedge mclk) begin
        if (adc_start === 1'b1) begin
            starts++;
            chk({31'h0, cpu1_halt}, 32'h1);
        end
    end
    // watchdog
    initial begin
        #100us;
        err_count++;
        wrap_up();
    end
    // main sequence
    initial begin
        cyc(8);
        rst <= 1'b0;
        cyc(1);
        chk({30'h0, hresp, hreadyout}, 32'h1);
        rdc(mcet_off_irq_stat, 32'h0);
        wr(8'h3c, 32'hffff_ffff);
        rdc(8'h3c, 32'h0);
        wr(mcet_off_ipi, 32'h2);
        cyc(2);
        chk({29'h0, irq, cpu2_ipi, cpu1_ipi}, 32'h2);
        wr(mcet_off_irq_mask, 32'hf);
        cyc(2);
        chk({31'h0, irq}, 32'h1);
        rdc(mcet_off_irq_stat, 32'h2);
        rdc(mcet_off_ipi, 32'h2);
        rdc(mcet_off_irq_mask, 32'hf);
        wr(mcet_off_ipi, 32'h1);
        wr(mcet_off_irq_stat, 32'h2);
        cyc(2);
        chk({30'h0, cpu2_ipi, cpu1_ipi}, 32'h1);
        wr(mcet_off_irq_stat, 32'h1);
        cyc(2);
        chk({29'h0, irq, cpu2_ipi, cpu1_ipi}, 32'h0);
        // channel enables, analogue settings, video map
        wr(mcet_off_chan_en, 32'ha5);
        wr(mcet_off_analog, 32'h12_3456);
        wr(mcet_off_video, 32'h1);
        cyc(2);
        chk({24'h0, chan_wr_en}, 32'ha5);
        chk({8'h0, analog_ctl}, 32'h12_3456);
        chk({31'h0, video_map}, 32'h1);
        rdc(mcet_off_analog, 32'h12_3456);
        wr(mcet_off_video, 32'h0);
        cyc(2);
        chk({31'h0, video_map}, 32'h0);
        // conversion waits for a pace pulse with processor one held
        wr(mcet_off_adc_ctl, 32'h1);
        cyc(20);
        chk({30'h0, cpu1_halt, adc_start}, 32'h2);
        rdc(mcet_off_adc_ctl, 32'h1);
        pace_en <= 1'b1;
        n = 0;
        while (cpu1_halt !== 1'b0 && n < 100) begin
            cyc(1);
            n++;
        end
        chk(32'(starts), 32'h1);
        rdc(mcet_off_adc_data, 32'h5a);
        rdc(mcet_off_irq_stat, 32'h8);
        wr(mcet_off_irq_stat, 32'h8);
        pace_en <= 1'b0;
        // playback on the system clock
        wr(mcet_off_tmr_load, 32'h5);
        wr(mcet_off_tmr_ctl, 32'h1);
        wait_irq();
        chk_in(32'(n), 4, 8);
        cyc(20);
        chk({31'h0, irq}, 32'h1);
        wr(mcet_off_tmr_ctl, 32'h0);
        wr(mcet_off_irq_stat, 32'h4);
        cyc(2);
        chk({31'h0, irq}, 32'h0);
        // playback on divided external sync
        wr(mcet_off_sync_div, 32'h3);
        rdc(mcet_off_sync_div, 32'h3);
        wr(mcet_off_tmr_load, 32'h2);
        wr(mcet_off_tmr_ctl, 32'h3);
        cyc(30);
        chk({31'h0, irq}, 32'h0);
        tick(3);
        chk({31'h0, irq}, 32'h0);
        tick(2);
        chk({31'h0, irq}, 32'h0);
        tick(2);
        chk({31'h0, irq}, 32'h1);
        wr(mcet_off_tmr_ctl, 32'h0);
        wr(mcet_off_irq_stat, 32'h4);
        // record: intervals between successive events
        wr(mcet_off_tmr_ctl, 32'h5);
        cyc(10);
        perf_event <= 1'b1;
        cyc(1);
        perf_event <= 1'b0;
        cyc(4);
        perf_event <= 1'b1;
        cyc(1);
        perf_event <= 1'b0;
        cyc(2);
        xfer(1'b0, mcet_off_tmr_count, 32'h0, rd);
        chk(rd, 32'h5);
        rdc(mcet_off_irq_stat, 32'h4);
        wrap_up();
    end
endmodule : tb_master_card_event_timer_and_sampler
`default_nettype wire
